// ===== hw/gis_params.svh
// offsets, field positions and reset values for the irq/poll status block
`ifndef GIS_PARAMS_SVH
`define GIS_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets, low five address bits, first port
// ---------------------------------------------------------------
`define GIS_OFF_DATA 5'h01
`define GIS_OFF_ST1 5'h03
`define GIS_OFF_ST2 5'h05
`define GIS_OFF_POLL 5'h07
`define GIS_OFF_ADDR 5'h09
`define GIS_PORT_STRIDE 5'h10

// ---------------------------------------------------------------
// flag vector positions
// ---------------------------------------------------------------
`define GIS_F_DO 0
`define GIS_F_DI 1
`define GIS_F_SRQ 2
`define GIS_F_CO 3
`define GIS_F_LOCKOUT_CHANGE 4
`define GIS_F_HOST_CONTROL_CHANGE 5
`define GIS_F_ADDR_STATE_CHANGE 6
`define GIS_NFLAG 7

// ---------------------------------------------------------------
// field positions in mask two and the poll byte
// ---------------------------------------------------------------
`define GIS_M2_SRQ 6
`define GIS_M2_XOUT 5
`define GIS_M2_XIN 4
`define GIS_POLL_RSV 6

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define GIS_RST_BYTE 8'h00

`endif

// ===== hw/gis_pkg.sv
// types shared by the irq/poll status block
package gis_pkg;

  // ---------------------------------------------------------------
  // state of the bus interface core seen by this block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic tacs;
    logic sgns;
    logic lacs;
    logic acds;
    logic cont_mode;
    logic rfd_hold;
    logic finish_hs;
    logic cids;
    logic cads;
    logic cacs;
    logic srq;
    logic rqs;
    logic dav;
    logic lwls;
    logic rwls;
    logic rems;
    logic atn_n;
    logic spms;
    logic lpas;
    logic tpas;
    logic la;
    logic ta;
    logic minor_rx;
    logic major_rx;
    logic ton;
    logic lon;
    logic nprs;
    logic aprs;
    logic spas;
    logic local_master_reset;
    logic chip_rst;
    logic ctl_stby_lsn;
  } gis_core_t;

  typedef enum logic [1:0] {
    POLL_IDLE,
    POLL_ARMED,
    POLL_SENT
  } gis_poll_st_t;

endpackage : gis_pkg

// ===== hw/gis_flag.sv
// one status flag whose update is held off while its register is read
`timescale 1ns/1ps
module gis_flag
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clr,
  input wire logic i_rd,
  output logic o_flag
);

  logic flag_reg;
  logic flag_next;
  logic pset_reg;
  logic pset_next;
  logic pclr_reg;
  logic pclr_next;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    flag_next = flag_reg;
    pset_next = pset_reg;
    pclr_next = pclr_reg;
    if (i_rd)
    begin
      // events during a read wait until the read is over
      flag_next = 1'b0; // RL5
      pset_next = pset_reg | i_set; // RL5
      pclr_next = pclr_reg | i_clr; // RL5
    end
    else
    begin
      // set wins so an event in the clearing cycle is kept
      if (i_set || pset_reg)
        flag_next = 1'b1;
      else if (i_clr || pclr_reg)
        flag_next = 1'b0;
      pset_next = 1'b0;
      pclr_next = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      flag_reg <= 1'b0;
      pset_reg <= 1'b0;
      pclr_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      pset_reg <= pset_next;
      pclr_reg <= pclr_next;
    end
  end

  assign o_flag = flag_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_read_hit;
    i_rd && i_set;
  endsequence

  read_defer_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL5
    s_read_hit ##1 !i_rd |-> !flag_reg ##1 flag_reg)
    else $error("deferred set was lost after a read");

endmodule : gis_flag

// ===== hw/gis_top.sv
// interrupt status, mask, serial poll and address status of one port
`timescale 1ns/1ps
`include "gis_params.svh"

// Overview of operation
// RL1 - data-out flag clears on outbound byte write or when talker goes inactive
// RL2 - data-in flag sets in listener active plus accept data, unless continuous
// RL3 - data-in clears on reset, status one read, inbound read, hold release
// RL4 - irq bit is OR of enabled status bits; drives interrupt pin
// RL5 - status two changes during its read wait until the read ends
// RL6 - status bits move regardless of enables; only irq uses enables
// RL7 - software keeps mask bit 7 zero and never sets transfer enables
// RL8 - service request seen sets on SRQ while in charge, not own request
// RL9 - lockout flag reads one in either lockout state; never interrupts
// RL10 - host-controlled flag reads one in remote or remote-with-lockout state
// RL11 - command-send-ready sets on controller active and source generate
// RL12 - lockout change sets on any lockout flag change; read clears
// RL13 - remote change sets on any host-controlled flag change; read clears
// RL14 - address change sets on talker/listener/in-charge/minor change, not only-modes
// RL15 - programmed poll byte sent after poll enable once controller stands by
// RL16 - poll request waiting sets on request write, clears on negative response
// RL17 - request bit set and not polled asserts SRQ
// RL18 - request bit clears at affirmative response, reset, master reset
// RL19 - status reads and mask writes share one offset; second port 0x10 up
// RL20 - software sets the core interrupt output active high
// RL21 - read-only address status register reports the addressing state
// RL22 - in-charge bit reads one unless controller idle or addressed idle
// RL23 - minor bit sets on minor address, clears on major address
// RL24 - each port is its own instance with its own registers and irq
module gis_top
#(
  parameter logic [4:0] P_PORT_BASE = 5'h00
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire gis_pkg::gis_core_t i_core,
  input wire logic [5:0] i_st1_other,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_srq,
  output logic o_stb_valid,
  output logic [7:0] o_stb_byte
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == 5'(P_PORT_BASE + off)); // RL19
  endfunction : hit

  logic rd_data;
  logic rd_st1;
  logic rd_st2;
  logic wr_data;
  logic wr_m1;
  logic wr_m2;
  logic wr_poll;

  assign rd_data = i_rd && hit(i_addr, `GIS_OFF_DATA);
  assign rd_st1 = i_rd && hit(i_addr, `GIS_OFF_ST1);
  assign rd_st2 = i_rd && hit(i_addr, `GIS_OFF_ST2);
  assign wr_data = i_wr && hit(i_addr, `GIS_OFF_DATA);
  assign wr_m1 = i_wr && hit(i_addr, `GIS_OFF_ST1);
  assign wr_m2 = i_wr && hit(i_addr, `GIS_OFF_ST2);
  assign wr_poll = i_wr && hit(i_addr, `GIS_OFF_POLL);

  // ---------------------------------------------------------------
  // conditions and their history
  // ---------------------------------------------------------------
  logic do_cond;
  logic di_cond;
  logic srq_cond;
  logic co_cond;
  logic cic_bit;
  logic [3:0] adr_bits;
  logic [3:0] cond_reg;
  logic [3:0] cond_next;
  logic [3:0] adr_reg;
  logic [3:0] adr_next;
  logic lok_reg;
  logic lok_next;
  logic rem_reg;
  logic rem_next;
  logic secondary_identity_sel_reg;
  logic secondary_identity_sel_next;

  assign do_cond = i_core.tacs && i_core.sgns;
  assign di_cond = i_core.lacs && i_core.acds && !i_core.cont_mode; // RL2
  assign cic_bit = !(i_core.cids || i_core.cads); // RL22
  assign srq_cond = cic_bit && i_core.srq
    && !(i_core.rqs && i_core.dav); // RL8
  assign co_cond = i_core.cacs && i_core.sgns; // RL11
  assign adr_bits = {i_core.ta, i_core.la, cic_bit, secondary_identity_sel_reg};

  always_comb
  begin
    cond_next = {do_cond, di_cond, srq_cond, co_cond};
    adr_next = adr_bits;
    lok_next = lok_reg;
    rem_next = rem_reg;
    // mirrors of the remote/local state also wait out a read
    if (!rd_st2)
    begin
      lok_next = i_core.lwls || i_core.rwls; // RL9
      rem_next = i_core.rems || i_core.rwls; // RL10
    end
    secondary_identity_sel_next = secondary_identity_sel_reg;
    if (i_core.chip_rst || i_core.major_rx)
      secondary_identity_sel_next = 1'b0; // RL23
    else if (i_core.minor_rx)
      secondary_identity_sel_next = 1'b1; // RL23
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cond_reg <= 4'h0;
      adr_reg <= 4'h0;
      lok_reg <= 1'b0;
      rem_reg <= 1'b0;
      secondary_identity_sel_reg <= 1'b0;
    end
    else
    begin
      cond_reg <= cond_next;
      adr_reg <= adr_next;
      lok_reg <= lok_next;
      rem_reg <= rem_next;
      secondary_identity_sel_reg <= secondary_identity_sel_next;
    end
  end

  // ---------------------------------------------------------------
  // sticky status flags
  // ---------------------------------------------------------------
  logic [`GIS_NFLAG-1:0] f_set;
  logic [`GIS_NFLAG-1:0] f_clr;
  logic [`GIS_NFLAG-1:0] f_rd;
  logic [`GIS_NFLAG-1:0] flag;

  always_comb
  begin
    f_set = '0;
    f_clr = '0;
    f_rd = {`GIS_NFLAG{rd_st2}};
    f_rd[`GIS_F_DO] = rd_st1;
    f_rd[`GIS_F_DI] = rd_st1; // RL3
    f_set[`GIS_F_DO] = do_cond && !cond_reg[3];
    f_clr[`GIS_F_DO] = wr_data || !do_cond; // RL1
    f_set[`GIS_F_DI] = di_cond && !cond_reg[2]; // RL2
    f_clr[`GIS_F_DI] = rd_data
      || (i_core.finish_hs && i_core.rfd_hold); // RL3
    f_set[`GIS_F_SRQ] = srq_cond && !cond_reg[1]; // RL8
    f_set[`GIS_F_CO] = co_cond && !cond_reg[0]; // RL11
    f_clr[`GIS_F_CO] = !co_cond; // RL11
    f_set[`GIS_F_LOCKOUT_CHANGE] = lok_next != lok_reg; // RL12
    f_set[`GIS_F_HOST_CONTROL_CHANGE] = rem_next != rem_reg; // RL13
    f_set[`GIS_F_ADDR_STATE_CHANGE] = (adr_bits != adr_reg)
      && !(i_core.ton || i_core.lon); // RL14
  end

  // flags move with no regard to their enables
  genvar gi;
  generate
    for (gi = 0; gi < `GIS_NFLAG; gi++)
    begin : g_flag
      gis_flag u_flag
      (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_set(f_set[gi]), // RL6
        .i_clr(f_clr[gi]),
        .i_rd(f_rd[gi]),
        .o_flag(flag[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // masks, poll byte and request state (one set per port instance)
  // ---------------------------------------------------------------
  logic [7:0] m1_reg;
  logic [7:0] m1_next;
  logic [7:0] m2_reg;
  logic [7:0] m2_next;
  logic [7:0] poll_reg;
  logic [7:0] poll_next;
  logic poll_request_waiting_reg;
  logic poll_request_waiting_next;
  logic irq_any;

  always_comb
  begin
    m1_next = wr_m1 ? i_wdata : m1_reg;
    // bits 7,5,4 are stored but steer nothing
    m2_next = wr_m2 ? i_wdata : m2_reg; // RL19
    poll_next = poll_reg;
    poll_request_waiting_next = poll_request_waiting_reg;
    if (i_core.chip_rst)
      poll_next = `GIS_RST_BYTE; // RL15
    else if (wr_poll)
      poll_next = i_wdata;
    else if (i_core.aprs || i_core.local_master_reset)
      poll_next[`GIS_POLL_RSV] = 1'b0; // RL18
    if (wr_poll && i_wdata[`GIS_POLL_RSV])
      poll_request_waiting_next = 1'b1; // RL16
    else if (i_core.nprs && poll_reg[`GIS_POLL_RSV])
      poll_request_waiting_next = 1'b0; // RL16
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      m1_reg <= `GIS_RST_BYTE;
      m2_reg <= `GIS_RST_BYTE;
      poll_reg <= `GIS_RST_BYTE;
      poll_request_waiting_reg <= 1'b0;
    end
    else
    begin
      m1_reg <= m1_next; // RL24
      m2_reg <= m2_next;
      poll_reg <= poll_next;
      poll_request_waiting_reg <= poll_request_waiting_next;
    end
  end

  // lockout and remote mirrors have no enable and never interrupt
  assign irq_any = |({i_st1_other, flag[`GIS_F_DO], flag[`GIS_F_DI]}
      & m1_reg)
    || (flag[`GIS_F_SRQ] && m2_reg[`GIS_M2_SRQ])
    || |({flag[`GIS_F_CO], flag[`GIS_F_LOCKOUT_CHANGE], flag[`GIS_F_HOST_CONTROL_CHANGE],
      flag[`GIS_F_ADDR_STATE_CHANGE]} & m2_reg[3:0]); // RL4

  // ---------------------------------------------------------------
  // serial poll response
  // ---------------------------------------------------------------
  gis_pkg::gis_poll_st_t poll_st_reg;
  gis_pkg::gis_poll_st_t poll_st_next;
  logic stb_valid_next;
  logic [7:0] stb_byte_next;

  always_comb
  begin
    poll_st_next = poll_st_reg;
    stb_valid_next = 1'b0;
    stb_byte_next = o_stb_byte;
    unique case (poll_st_reg)
      gis_pkg::POLL_IDLE:
        if (i_core.ta && i_core.spms)
          poll_st_next = gis_pkg::POLL_ARMED;
      gis_pkg::POLL_ARMED:
        if (!(i_core.ta && i_core.spms))
          poll_st_next = gis_pkg::POLL_IDLE;
        else if (i_core.ctl_stby_lsn)
        begin
          stb_valid_next = 1'b1; // RL15
          stb_byte_next = poll_reg; // RL15
          poll_st_next = gis_pkg::POLL_SENT;
        end
      gis_pkg::POLL_SENT:
        // one byte per standby so a long standby sends no repeats
        if (!i_core.ctl_stby_lsn)
          poll_st_next = gis_pkg::POLL_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      poll_st_reg <= gis_pkg::POLL_IDLE;
      o_stb_valid <= 1'b0;
      o_stb_byte <= `GIS_RST_BYTE;
    end
    else
    begin
      poll_st_reg <= poll_st_next;
      o_stb_valid <= stb_valid_next;
      o_stb_byte <= stb_byte_next;
    end
  end

  // ---------------------------------------------------------------
  // read data and pins
  // ---------------------------------------------------------------
  logic [7:0] rdata_next;

  always_comb
  begin
    rdata_next = `GIS_RST_BYTE;
    if (rd_st1)
      rdata_next = {i_st1_other, flag[`GIS_F_DO], flag[`GIS_F_DI]};
    else if (rd_st2)
      rdata_next = {o_irq, flag[`GIS_F_SRQ], lok_reg, rem_reg,
        flag[`GIS_F_CO], flag[`GIS_F_LOCKOUT_CHANGE], flag[`GIS_F_HOST_CONTROL_CHANGE],
        flag[`GIS_F_ADDR_STATE_CHANGE]}; // RL19
    else if (i_rd && hit(i_addr, `GIS_OFF_POLL))
      rdata_next = {poll_reg[7], poll_request_waiting_reg, poll_reg[5:0]};
    else if (i_rd && hit(i_addr, `GIS_OFF_ADDR))
      rdata_next = {cic_bit, i_core.atn_n, i_core.spms, i_core.lpas,
        i_core.tpas, i_core.la, i_core.ta, secondary_identity_sel_reg}; // RL21
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= `GIS_RST_BYTE;
      o_irq <= 1'b0;
      o_srq <= 1'b0;
    end
    else
    begin
      o_rdata <= rdata_next;
      o_irq <= irq_any; // RL4
      o_srq <= poll_reg[`GIS_POLL_RSV] && !i_core.spas; // RL17
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  irq_pin_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL4
    (m1_reg == 8'h00 && m2_reg == 8'h00) [*2] |-> !o_irq)
    else $error("irq raised with every enable clear");

  lok_mirror_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL9
    !rd_st2 |=> lok_reg == $past(i_core.lwls || i_core.rwls))
    else $error("lockout flag does not follow lockout states");

  rem_mirror_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL10
    !rd_st2 |=> rem_reg == $past(i_core.rems || i_core.rwls))
    else $error("host-controlled flag does not follow remote states");

  lok_change_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL12
    $changed(lok_reg) |-> flag[`GIS_F_LOCKOUT_CHANGE])
    else $error("lockout change not flagged");

  do_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL1
    !do_cond && !rd_st1 ##1 !do_cond && !rd_st1 |-> !flag[`GIS_F_DO])
    else $error("data-out flag held while talker inactive");

  poll_request_waiting_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL16
    wr_poll && i_wdata[`GIS_POLL_RSV] |=> poll_request_waiting_reg)
    else $error("request write did not set waiting flag");

  srq_drive_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL17
    poll_reg[`GIS_POLL_RSV] && !i_core.spas |=> o_srq)
    else $error("SRQ not asserted for pending request");

  rsv_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL18
    (i_core.aprs || i_core.local_master_reset) && !wr_poll |=> !poll_reg[`GIS_POLL_RSV])
    else $error("request bit survived affirmative response");

  secondary_identity_sel_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL23
    i_core.minor_rx && !i_core.major_rx && !i_core.chip_rst |=> secondary_identity_sel_reg)
    else $error("minor address did not set minor bit");

  cic_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RL22
    i_rd && hit(i_addr, `GIS_OFF_ADDR)
      |=> o_rdata[7] == $past(!(i_core.cids || i_core.cads)))
    else $error("in-charge bit wrong on address status read");

endmodule : gis_top

// ===== verification/gis_bus_model.sv
// far-side bus model: holds the core state and runs serial polls
`timescale 1ns/1ps
module gis_bus_model
(
  input wire logic i_mclk,
  input wire logic i_srq,
  input wire logic i_stb_valid,
  input wire logic [7:0] i_stb_byte,
  input wire logic i_poll_en,
  input wire logic [3:0] i_delay,
  output gis_pkg::gis_core_t o_core,
  output logic [7:0] o_seen
);
  gis_pkg::gis_core_t core_q;
  int n;

  assign o_core = core_q;

  initial
  begin
    core_q = '0;
    core_q.cids = 1'b1;
    core_q.atn_n = 1'b1;
    o_seen = 8'h00;
  end

  // ---------------------------------------------------------------
  // controller answers a service request with a serial poll
  // ---------------------------------------------------------------
  // delay sets a prompt or a slow controller
  always @(posedge i_mclk)
  begin
    if (i_poll_en && i_srq)
    begin
      repeat (i_delay) @(posedge i_mclk);
      core_q.ta <= 1'b1;
      core_q.spms <= 1'b1;
      core_q.spas <= 1'b1;
      repeat (i_delay) @(posedge i_mclk);
      core_q.ctl_stby_lsn <= 1'b1;
      n = 0;
      // bounded: a silent device must not hang the controller
      while (!i_stb_valid && n < 64)
      begin
        @(posedge i_mclk);
        n++;
      end
      o_seen <= i_stb_byte;
      core_q.aprs <= 1'b1;
      @(posedge i_mclk);
      core_q.aprs <= 1'b0;
      core_q.ta <= 1'b0;
      core_q.spms <= 1'b0;
      core_q.spas <= 1'b0;
      core_q.ctl_stby_lsn <= 1'b0;
    end
  end
endmodule : gis_bus_model

// ===== verification/gis_irq_status_poll_tb.sv
// self-checking bench for the irq, poll and address status block
`timescale 1ns/1ps
module gis_irq_status_poll_tb;
  logic i_mclk;
  logic i_rst_n;
  logic [4:0] i_addr;
  logic i_rd;
  logic i_wr;
  logic [7:0] i_wdata;
  logic [5:0] i_st1_other;
  logic poll_en;
  logic [3:0] poll_dly;
  logic [7:0] rd_a, rd_b, stb_byte, seen, pb;
  logic irq_a, srq_a, stb_valid;
  gis_pkg::gis_core_t core, c;
  int mismatches;
  int checks;
  int n;

  gis_top #(.P_PORT_BASE(5'h00)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_core(core), .i_st1_other(i_st1_other), .o_rdata(rd_a),
    .o_irq(irq_a), .o_srq(srq_a), .o_stb_valid(stb_valid),
    .o_stb_byte(stb_byte));
  gis_top #(.P_PORT_BASE(5'h10)) uut_b (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_core(core), .i_st1_other(i_st1_other), .o_rdata(rd_b),
    .o_irq(), .o_srq(), .o_stb_valid(), .o_stb_byte());
  gis_bus_model bus (.i_mclk(i_mclk), .i_srq(srq_a),
    .i_stb_valid(stb_valid), .i_stb_byte(stb_byte), .i_poll_en(poll_en),
    .i_delay(poll_dly), .o_core(core), .o_seen(seen));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic idle(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask : idle

  task automatic put;
    @(posedge i_mclk);
    bus.core_q <= c;
  endtask : put

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk((rd_a | rd_b) & m, e);
  endtask : rd

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // generous: the whole sequence needs about three hundred cycles
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    i_rst_n = 1'b0;
    i_addr = 5'h00;
    i_rd = 1'b0;
    i_wr = 1'b0;
    i_wdata = 8'h00;
    i_st1_other = 6'h00;
    poll_en = 1'b0;
    poll_dly = 4'h1;
    c = '0;
    c.cids = 1'b1;
    c.atn_n = 1'b1;
    checks = 0;
    mismatches = 0;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    c.lwls = 1'b1; put(); idle(3);
    rd(5'h05, 8'hff, 8'h24);
    rd(5'h05, 8'hff, 8'h20);
    rd(5'h15, 8'hff, 8'h24);
    c.lwls = 1'b0; c.rwls = 1'b1; put(); idle(3);
    rd(5'h05, 8'hff, 8'h32);
    c.rwls = 1'b0; put(); idle(3);
    rd(5'h05, 8'hff, 8'h06);
    @(posedge i_mclk);
    i_addr <= 5'h05;
    i_rd <= 1'b1;
    c.rems = 1'b1;
    bus.core_q <= c;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(rd_a, 8'h00);
    idle(2);
    rd(5'h05, 8'hff, 8'h12);
    c.rems = 1'b0; put(); idle(3);
    rd(5'h05, 8'hff, 8'h02);
    rd(5'h0b, 8'hff, 8'h00);
    wr(5'h09, 8'hff);
    rd(5'h09, 8'hff, 8'h40);
    $display("test lockout and remote done");
    c.cids = 1'b0; put(); idle(3);
    rd(5'h09, 8'hff, 8'hc0);
    rd(5'h05, 8'hff, 8'h01);
    c.ton = 1'b1; c.ta = 1'b1; put(); idle(3);
    rd(5'h09, 8'hff, 8'hc2);
    rd(5'h05, 8'hff, 8'h00);
    c.ton = 1'b0; c.ta = 1'b0; c.la = 1'b1; c.spms = 1'b1;
    c.lpas = 1'b1; c.tpas = 1'b1; c.atn_n = 1'b0; put(); idle(3);
    rd(5'h09, 8'hff, 8'hbc);
    rd(5'h05, 8'hff, 8'h01);
    c.minor_rx = 1'b1; put(); c.minor_rx = 1'b0; put(); idle(3);
    rd(5'h09, 8'h01, 8'h01);
    rd(5'h05, 8'hff, 8'h01);
    c.major_rx = 1'b1; put(); c.major_rx = 1'b0; put(); idle(3);
    rd(5'h09, 8'h01, 8'h00);
    c.rqs = 1'b1; c.dav = 1'b1; c.srq = 1'b1; put(); idle(3);
    rd(5'h05, 8'h40, 8'h00);
    c.srq = 1'b0; put(); c.rqs = 1'b0; c.dav = 1'b0; put();
    c.srq = 1'b1; put(); idle(3);
    rd(5'h05, 8'h40, 8'h40);
    rd(5'h05, 8'h40, 8'h00);
    c.srq = 1'b0; c.cacs = 1'b1; c.sgns = 1'b1; put(); idle(3);
    rd(5'h05, 8'h08, 8'h08);
    rd(5'h05, 8'h08, 8'h00);
    c.sgns = 1'b0; put(); c.sgns = 1'b1; put(); idle(3);
    c.cacs = 1'b0; put(); idle(3);
    rd(5'h05, 8'h08, 8'h00);
    c = '0; c.cids = 1'b1; c.atn_n = 1'b1; put(); idle(3);
    rd(5'h05, 8'hff, 8'h01);
    $display("test address state done");
    c.tacs = 1'b1; c.sgns = 1'b1; put(); idle(3);
    rd(5'h03, 8'h03, 8'h02);
    rd(5'h03, 8'h03, 8'h00);
    c.sgns = 1'b0; put(); c.sgns = 1'b1; put(); idle(3);
    wr(5'h01, 8'h55); idle(2);
    rd(5'h03, 8'h03, 8'h00);
    c.sgns = 1'b0; put(); c.sgns = 1'b1; put(); idle(3);
    c.tacs = 1'b0; put(); idle(3);
    rd(5'h03, 8'h03, 8'h00);
    c.sgns = 1'b0; c.lacs = 1'b1; c.acds = 1'b1; put(); idle(3);
    rd(5'h01, 8'hff, 8'h00);
    rd(5'h03, 8'h03, 8'h00);
    c.acds = 1'b0; put(); c.acds = 1'b1; put(); idle(3);
    rd(5'h03, 8'h03, 8'h01);
    c.acds = 1'b0; put(); c.acds = 1'b1; c.rfd_hold = 1'b1; put();
    c.finish_hs = 1'b1; put(); c.finish_hs = 1'b0; put(); idle(3);
    rd(5'h03, 8'h03, 8'h00);
    c.cont_mode = 1'b1; c.acds = 1'b0; put(); c.acds = 1'b1; put(); idle(3);
    rd(5'h03, 8'h03, 8'h00);
    c.cont_mode = 1'b0; c.acds = 1'b0; put(); c.acds = 1'b1; put(); idle(3);
    chk({7'h00, irq_a}, 8'h00);
    wr(5'h03, 8'h01); idle(2);
    chk({7'h00, irq_a}, 8'h01);
    rd(5'h05, 8'h80, 8'h80);
    rd(5'h03, 8'h03, 8'h01); idle(2);
    chk({7'h00, irq_a}, 8'h00);
    i_st1_other <= 6'h2a;
    wr(5'h03, 8'h08); idle(2);
    chk({7'h00, irq_a}, 8'h01);
    rd(5'h03, 8'hfc, 8'ha8);
    i_st1_other <= 6'h00;
    wr(5'h03, 8'h00);
    wr(5'h05, 8'h02);
    c.rems = 1'b1; put(); idle(3);
    chk({7'h00, irq_a}, 8'h01);
    rd(5'h05, 8'hff, 8'h92); idle(2);
    chk({7'h00, irq_a}, 8'h00);
    wr(5'h05, 8'h00);
    $display("test data flags and irq done");
    for (int k = 0; k < 2; k++)
    begin
      pb = (k == 0) ? 8'h4a : 8'hc5;
      poll_dly <= (k == 0) ? 4'h1 : 4'h8;
      wr(5'h07, pb); idle(2);
      chk({7'h00, srq_a}, 8'h01);
      rd(5'h07, 8'hff, pb);
      poll_en <= 1'b1;
      n = 0;
      while (seen !== pb && n < 100)
      begin
        @(posedge i_mclk);
        n++;
      end
      chk(seen, pb);
      idle(3);
      chk({7'h00, srq_a}, 8'h00);
      poll_en <= 1'b0;
      rd(5'h07, 8'hbf, pb & 8'hbf);
    end
    wr(5'h07, 8'h40); idle(2);
    chk({7'h00, srq_a}, 8'h01);
    c.nprs = 1'b1; put(); c.nprs = 1'b0; put(); idle(3);
    rd(5'h07, 8'h40, 8'h00);
    c.local_master_reset = 1'b1; put(); c.local_master_reset = 1'b0; put(); idle(3);
    chk({7'h00, srq_a}, 8'h00);
    c.chip_rst = 1'b1; put(); c.chip_rst = 1'b0; put(); idle(3);
    rd(5'h07, 8'hbf, 8'h00);
    $display("test serial poll done");
    complete_run();
  end
endmodule : gis_irq_status_poll_tb
